/* core/tcmc_pkg.sv */
// Purpose: Shared constants for the two-set cache and memory control unit
// Assumes: 100 MHz clock, word addresses of 16-bit words
// Notes: Cache index, page and word fields are slices of the word address
package tcmc_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int REFRESH_NS = 16000;
  localparam int REFRESH_CYC = REFRESH_NS / CLK_PERIOD_NS;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 20;
  localparam int WSEL_LSB = 0;
  localparam int PAIR_LSB = 2;
  localparam int IDX_LSB = 2;
  localparam int IDX_W = 8;
  localparam int PAGE_LSB = 10;
  localparam int PAGE_W = 10;
  localparam int BLK_WORDS = 4;
  localparam int SETS = 2;
  localparam int CACHE_BYTES = 4096;
  localparam int DW_W = 32;
  localparam int CHK_W = 7;
  localparam int SYN_W = 6;
  localparam int CODE_W = DW_W + SYN_W;
  localparam int LANE_W = DW_W + CHK_W;
  localparam int LANES = 2;
  localparam int ROW_W = 16;
  localparam int BANK_W = 2;
  localparam logic [1:0] SIZE_512K = 2'h0;
  localparam logic [1:0] SIZE_1M = 2'h1;
  localparam logic [1:0] SIZE_2M = 2'h2;
  localparam logic LRU_RESET = 1'b0;
  typedef enum logic [1:0] {OWN_CPU, OWN_DCH, OWN_BMC, OWN_REF} tcmc_owner_t;
endpackage

/* core/tcmc_ecc_if.sv */
// Purpose: Carries a double-word pair between controller and check logic
// Assumes: Lane layout is {check, data}
// Notes: None
`timescale 1ns/1ps
interface tcmc_ecc_if;
  logic [tcmc_pkg::LANES-1:0][tcmc_pkg::LANE_W-1:0] raw;
  logic [tcmc_pkg::LANES-1:0][tcmc_pkg::DW_W-1:0] fixed;
  logic [tcmc_pkg::LANES-1:0] single;
  logic [tcmc_pkg::LANES-1:0] multi;
  logic [tcmc_pkg::LANES-1:0][tcmc_pkg::DW_W-1:0] enc_data;
  logic [tcmc_pkg::LANES-1:0][tcmc_pkg::CHK_W-1:0] enc_chk;
  modport core (output raw, enc_data, input fixed, single, multi, enc_chk);
  modport ecc (input raw, enc_data, output fixed, single, multi, enc_chk);
endinterface

/* core/tcmc_ecc.sv */
// Purpose: Single-correct double-detect code over 32 data bits, two lanes
// Assumes: Hamming positions 1..38 plus an overall parity bit
// Notes: Purely combinational
`timescale 1ns/1ps
module tcmc_ecc (
  tcmc_ecc_if.ecc port
);
  function automatic logic [tcmc_pkg::CODE_W:1] spread(input logic [tcmc_pkg::DW_W-1:0] d);
    int k;
    k = 0;
    spread = '0;
    for (int p = 1; p <= tcmc_pkg::CODE_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        spread[p] = d[k];
        k++;
      end
    end
  endfunction

  function automatic logic [tcmc_pkg::DW_W-1:0] gather(input logic [tcmc_pkg::CODE_W:1] c);
    int k;
    k = 0;
    gather = '0;
    for (int p = 1; p <= tcmc_pkg::CODE_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        gather[k] = c[p];
        k++;
      end
    end
  endfunction

  function automatic logic [tcmc_pkg::SYN_W-1:0] synd(input logic [tcmc_pkg::CODE_W:1] c);
    synd = '0;
    for (int p = 1; p <= tcmc_pkg::CODE_W; p++) begin
      if (c[p]) begin
        synd = synd ^ tcmc_pkg::SYN_W'(p);
      end
    end
  endfunction

  always_comb begin
    logic [tcmc_pkg::CODE_W:1] c;
    logic [tcmc_pkg::SYN_W-1:0] s;
    logic [tcmc_pkg::SYN_W-1:0] e;
    logic par;
    logic fits;
    c = '0;
    s = '0;
    e = '0;
    par = 1'b0;
    fits = 1'b0;
    for (int l = 0; l < tcmc_pkg::LANES; l++) begin
      c = spread(port.raw[l][tcmc_pkg::DW_W-1:0]);
      for (int j = 0; j < tcmc_pkg::SYN_W; j++) begin
        c[1 << j] = port.raw[l][tcmc_pkg::DW_W + j];
      end
      s = synd(c);
      par = ^port.raw[l];
      fits = (32'(s) <= tcmc_pkg::CODE_W);
      if (par && s != '0 && fits) begin
        c[s] = ~c[s];
      end
      port.fixed[l] = gather(c);
      port.single[l] = par && fits;
      port.multi[l] = (!par && s != '0) || (par && !fits);
      e = synd(spread(port.enc_data[l]));
      port.enc_chk[l] = {^{e, port.enc_data[l]}, e};
    end
  end
endmodule

/* core/tcmc_top.sv */
// Purpose: Two-set write-through cache and three-port memory control unit
// Assumes: Memory answers each mem_req with a one-cycle mem_ack
// Notes: One memory operation outstanding; stores are read-modify-write
// Behaviour
// - 4 KB cache, two sets of 256 blocks
// - Block n maps to index n; page tag kept
// - One LRU flag per index marks unused set
// - Miss fills set1 if flag 1, else set2
// - Read hit returns cached word, updates flag
// - Every processor store goes to memory
// - Store hit also updates cached copy
// - Store miss never allocates a block
// - Channel write hit invalidates cached block
// - Invalidate all at reset and console entry
// - Channel transfers never read or fill cache
// - Priority: data channel, burst, then processor
// - Three module sizes with bank layouts
// - Double word is 32 data, 7 check
// - Two banks alternate per double-word pair
// - Four banks rotate per double-word pair
// - Address selects pair; lane select picks words
// - Refresh cycle every 16 microseconds
// - Correct single, detect double errors, record
// - Software enables correction, reads error info
// - Refresh sniffs a pair, rewrites corrected
// - Reads corrected before delivery to requester
`timescale 1ns/1ps
module tcmc_top #(
  parameter int REFRESH_CYC = tcmc_pkg::REFRESH_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic [tcmc_pkg::ADDR_W-1:0] cpu_addr,
  input wire logic [tcmc_pkg::WORD_W-1:0] cpu_wdata,
  output logic cpu_done,
  output logic [tcmc_pkg::WORD_W-1:0] cpu_rdata,
  input wire logic dch_req,
  input wire logic dch_we,
  input wire logic [tcmc_pkg::ADDR_W-1:0] dch_addr,
  input wire logic [tcmc_pkg::WORD_W-1:0] dch_wdata,
  output logic dch_done,
  input wire logic bmc_req,
  input wire logic bmc_we,
  input wire logic [tcmc_pkg::ADDR_W-1:0] bmc_addr,
  input wire logic [tcmc_pkg::WORD_W-1:0] bmc_wdata,
  output logic bmc_done,
  output logic [tcmc_pkg::WORD_W-1:0] io_rdata,
  input wire logic vcon_enter,
  input wire logic [1:0] mod_size,
  input wire logic ecc_enable,
  input wire logic err_clear,
  output logic err_single,
  output logic err_multi,
  output logic [tcmc_pkg::ADDR_W-1:0] err_addr,
  output logic mem_req,
  output logic mem_we,
  output logic mem_refresh,
  output logic [tcmc_pkg::BANK_W-1:0] mem_bank,
  output logic [tcmc_pkg::ROW_W-1:0] mem_row,
  output logic [tcmc_pkg::LANES-1:0] mem_sel,
  output logic [tcmc_pkg::LANES*tcmc_pkg::LANE_W-1:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [tcmc_pkg::LANES*tcmc_pkg::LANE_W-1:0] mem_rdata
);
  localparam int NIDX = 1 << tcmc_pkg::IDX_W;
  localparam int CNT_W = $clog2(REFRESH_CYC + 1);
  if (REFRESH_CYC < 1) begin
    $error("Refresh interval must be at least one cycle");
  end
  if (tcmc_pkg::SETS * NIDX * tcmc_pkg::BLK_WORDS * 2 != tcmc_pkg::CACHE_BYTES) begin
    $error("Cache geometry does not give the cache size");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_WR} tcmc_state_t;
  typedef logic [tcmc_pkg::ADDR_W-1:0] tcmc_addr_t;

  ////////////////////////////////////////////////////////////////////////
  // Cache storage
  logic [tcmc_pkg::WORD_W-1:0] cdata [tcmc_pkg::SETS][NIDX][tcmc_pkg::BLK_WORDS];
  logic [tcmc_pkg::PAGE_W-1:0] ctag [tcmc_pkg::SETS][NIDX];
  logic [tcmc_pkg::SETS-1:0] valid [NIDX];
  logic lru [NIDX];

  function automatic logic [tcmc_pkg::IDX_W-1:0] idx_of(input tcmc_addr_t a);
    idx_of = a[tcmc_pkg::IDX_LSB +: tcmc_pkg::IDX_W];
  endfunction

  // Way hit mask for an address
  function automatic logic [tcmc_pkg::SETS-1:0] hits(input tcmc_addr_t a);
    for (int w = 0; w < tcmc_pkg::SETS; w++) begin
      hits[w] = valid[idx_of(a)][w]
                && ctag[w][idx_of(a)] == a[tcmc_pkg::PAGE_LSB +: tcmc_pkg::PAGE_W];
    end
  endfunction

  function automatic logic [tcmc_pkg::BANK_W-1:0] bank_of(input tcmc_addr_t a,
                                                          input logic [1:0] sz);
    bank_of = (sz == tcmc_pkg::SIZE_1M) ? {1'b0, a[tcmc_pkg::PAIR_LSB]}
                                        : a[tcmc_pkg::PAIR_LSB +: 2];
  endfunction

  function automatic logic [tcmc_pkg::ROW_W-1:0] row_of(input tcmc_addr_t a, input logic [1:0] sz);
    row_of = (sz == tcmc_pkg::SIZE_1M) ? a[tcmc_pkg::PAIR_LSB + 1 +: tcmc_pkg::ROW_W]
                                       : a[tcmc_pkg::PAIR_LSB + 2 +: tcmc_pkg::ROW_W];
  endfunction

  tcmc_state_t state, next_state;
  tcmc_pkg::tcmc_owner_t own, next_own;
  tcmc_addr_t addr, next_addr, sniff, next_sniff, next_err_addr;
  logic we, next_we, ref_due, next_ref_due;
  logic [tcmc_pkg::WORD_W-1:0] wdata, next_wdata;
  logic [CNT_W-1:0] ref_cnt, next_ref_cnt;
  logic next_cpu_done, next_dch_done, next_bmc_done, next_err_single, next_err_multi;
  logic [tcmc_pkg::WORD_W-1:0] next_cpu_rdata, next_io_rdata;
  logic next_mem_req, next_mem_we, next_mem_refresh;
  logic [tcmc_pkg::BANK_W-1:0] next_mem_bank;
  logic [tcmc_pkg::ROW_W-1:0] next_mem_row;
  logic [tcmc_pkg::LANES-1:0] next_mem_sel;
  logic [tcmc_pkg::LANES*tcmc_pkg::LANE_W-1:0] next_mem_wdata;
  // Cache update strobes
  logic fill_en, word_en, lru_en, inv_en, lru_val, fill_way, word_way;
  logic [tcmc_pkg::SETS-1:0] inv_ways;
  logic [tcmc_pkg::IDX_W-1:0] fill_idx, word_idx, lru_idx, inv_idx;
  logic [tcmc_pkg::PAGE_W-1:0] fill_page;
  logic [1:0] word_sel;
  logic [tcmc_pkg::WORD_W-1:0] word_val;
  logic [tcmc_pkg::LANES-1:0][tcmc_pkg::DW_W-1:0] lane_data, merged;
  // Arbitration
  logic gap, go;
  tcmc_pkg::tcmc_owner_t g_own;
  tcmc_addr_t g_addr;
  logic g_we;
  logic [tcmc_pkg::WORD_W-1:0] g_wdata;
  logic [tcmc_pkg::SETS-1:0] cpu_hit, g_hit;

  tcmc_ecc_if ecc_bus ();
  tcmc_ecc u_ecc (.port(ecc_bus.ecc));

  ////////////////////////////////////////////////////////////////////////
  // Correction path and store merge
  always_comb begin
    for (int l = 0; l < tcmc_pkg::LANES; l++) begin
      ecc_bus.raw[l] = mem_rdata[l*tcmc_pkg::LANE_W +: tcmc_pkg::LANE_W];
      lane_data[l] = ecc_enable ? ecc_bus.fixed[l] : ecc_bus.raw[l][tcmc_pkg::DW_W-1:0];
    end
    merged = lane_data;
    // Only stores merge; reads must deliver memory data untouched
    if (own != tcmc_pkg::OWN_REF && we) begin
      merged[addr[tcmc_pkg::WSEL_LSB + 1]]
            [addr[tcmc_pkg::WSEL_LSB]*tcmc_pkg::WORD_W +: tcmc_pkg::WORD_W] = wdata;
    end
    ecc_bus.enc_data = merged;
  end

  // Fixed-priority grant; refresh ahead of all ports
  always_comb begin
    gap = cpu_done | dch_done | bmc_done;
    cpu_hit = hits(cpu_addr);
    go = 1'b1;
    g_own = tcmc_pkg::OWN_CPU;
    g_addr = cpu_addr;
    g_we = cpu_we;
    g_wdata = cpu_wdata;
    if (ref_due) begin
      g_own = tcmc_pkg::OWN_REF;
      g_addr = sniff;
      g_we = 1'b0;
    end else if (dch_req) begin
      g_own = tcmc_pkg::OWN_DCH;
      g_addr = dch_addr;
      g_we = dch_we;
      g_wdata = dch_wdata;
    end else if (bmc_req) begin
      g_own = tcmc_pkg::OWN_BMC;
      g_addr = bmc_addr;
      g_we = bmc_we;
      g_wdata = bmc_wdata;
    end else begin
      go = cpu_req;
    end
    if (state != ST_IDLE || gap) go = 1'b0;
    g_hit = hits(g_addr);
  end

  ////////////////////////////////////////////////////////////////////////
  // Control next state
  always_comb begin
    next_state = state;
    next_own = own;
    next_addr = addr;
    next_we = we;
    next_wdata = wdata;
    next_sniff = sniff;
    next_cpu_done = 1'b0;
    next_dch_done = 1'b0;
    next_bmc_done = 1'b0;
    next_cpu_rdata = cpu_rdata;
    next_io_rdata = io_rdata;
    next_mem_req = mem_req & ~mem_ack;
    next_mem_we = mem_we;
    next_mem_refresh = mem_refresh;
    next_mem_bank = mem_bank;
    next_mem_row = mem_row;
    next_mem_sel = mem_sel;
    next_mem_wdata = mem_wdata;
    next_err_single = err_single & ~err_clear;
    next_err_multi = err_multi & ~err_clear;
    next_err_addr = err_addr;
    fill_en = 1'b0;
    fill_way = 1'b0;
    fill_idx = idx_of(addr);
    fill_page = addr[tcmc_pkg::PAGE_LSB +: tcmc_pkg::PAGE_W];
    word_en = 1'b0;
    word_way = cpu_hit[1];
    word_idx = idx_of(cpu_addr);
    word_sel = cpu_addr[tcmc_pkg::WSEL_LSB +: 2];
    word_val = cpu_wdata;
    lru_en = 1'b0;
    lru_idx = idx_of(cpu_addr);
    lru_val = cpu_hit[1];
    inv_en = 1'b0;
    inv_ways = g_hit;
    inv_idx = idx_of(g_addr);
    next_ref_cnt = (ref_cnt == '0) ? CNT_W'(REFRESH_CYC - 1) : ref_cnt - 1'b1;
    next_ref_due = (ref_due & ~(go && g_own == tcmc_pkg::OWN_REF)) | (ref_cnt == '0);
    unique case (state)
      ST_IDLE: begin
        if (go && g_own == tcmc_pkg::OWN_CPU && !g_we && |cpu_hit) begin
          next_cpu_done = 1'b1;
          next_cpu_rdata = cdata[cpu_hit[1]][idx_of(cpu_addr)][word_sel];
          lru_en = 1'b1;
        end else if (go) begin
          next_own = g_own;
          next_addr = g_addr;
          next_we = g_we;
          next_wdata = g_wdata;
          next_mem_req = 1'b1;
          next_mem_we = 1'b0;
          next_mem_refresh = (g_own == tcmc_pkg::OWN_REF);
          next_mem_bank = bank_of(g_addr, mod_size);
          next_mem_row = row_of(g_addr, mod_size);
          // Whole pair for fills and sniffs, one lane otherwise
          next_mem_sel = (g_own == tcmc_pkg::OWN_REF || (g_own == tcmc_pkg::OWN_CPU && !g_we))
                         ? 2'h3 : (g_addr[tcmc_pkg::WSEL_LSB + 1] ? 2'h2 : 2'h1);
          next_state = ST_RD;
          if (g_own == tcmc_pkg::OWN_REF) begin
            next_sniff = sniff + tcmc_addr_t'(tcmc_pkg::BLK_WORDS);
            if (mod_size != tcmc_pkg::SIZE_2M) next_sniff[tcmc_pkg::ADDR_W-1] = 1'b0;
            if (mod_size == tcmc_pkg::SIZE_512K) next_sniff[tcmc_pkg::ADDR_W-2] = 1'b0;
          end
          word_en = g_own == tcmc_pkg::OWN_CPU && g_we && |cpu_hit;
          inv_en = g_own != tcmc_pkg::OWN_CPU && g_own != tcmc_pkg::OWN_REF && g_we;
        end
      end
      ST_RD: begin
        if (mem_ack) begin
          next_state = ST_IDLE;
          // Record errors on sniffs and reads
          if (ecc_enable && |((ecc_bus.single | ecc_bus.multi) & mem_sel)) begin
            next_err_single = next_err_single | |(ecc_bus.single & mem_sel);
            next_err_multi = next_err_multi | |(ecc_bus.multi & mem_sel);
            next_err_addr = addr;
          end
          for (int l = 0; l < tcmc_pkg::LANES; l++) begin
            next_mem_wdata[l*tcmc_pkg::LANE_W +: tcmc_pkg::LANE_W] =
                {ecc_bus.enc_chk[l], merged[l]};
          end
          if (own == tcmc_pkg::OWN_REF) begin
            if (ecc_enable && |(ecc_bus.single & mem_sel)) begin
              next_mem_req = 1'b1;
              next_mem_we = 1'b1;
              next_mem_sel = ecc_bus.single & mem_sel;
              next_state = ST_WR;
            end
          end else if (we) begin
            next_mem_req = 1'b1;
            next_mem_we = 1'b1;
            next_state = ST_WR;
          end else if (own == tcmc_pkg::OWN_CPU) begin
            fill_en = 1'b1;
            fill_way = ~lru[fill_idx];
            lru_en = 1'b1;
            lru_idx = fill_idx;
            lru_val = ~lru[fill_idx];
            next_cpu_done = 1'b1;
            next_cpu_rdata = merged[addr[1]][addr[0]*tcmc_pkg::WORD_W +: tcmc_pkg::WORD_W];
          end else begin
            next_io_rdata = merged[addr[1]][addr[0]*tcmc_pkg::WORD_W +: tcmc_pkg::WORD_W];
            next_dch_done = own == tcmc_pkg::OWN_DCH;
            next_bmc_done = own == tcmc_pkg::OWN_BMC;
          end
        end
      end
      ST_WR: begin
        if (mem_ack) begin
          next_state = ST_IDLE;
          next_cpu_done = own == tcmc_pkg::OWN_CPU;
          next_dch_done = own == tcmc_pkg::OWN_DCH;
          next_bmc_done = own == tcmc_pkg::OWN_BMC;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      own <= tcmc_pkg::OWN_CPU;
      addr <= '0;
      we <= 1'b0;
      wdata <= '0;
      sniff <= '0;
      ref_cnt <= CNT_W'(REFRESH_CYC - 1);
      ref_due <= 1'b0;
      cpu_done <= 1'b0;
      dch_done <= 1'b0;
      bmc_done <= 1'b0;
      cpu_rdata <= '0;
      io_rdata <= '0;
      err_single <= 1'b0;
      err_multi <= 1'b0;
      err_addr <= '0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_refresh <= 1'b0;
      mem_bank <= '0;
      mem_row <= '0;
      mem_sel <= '0;
      mem_wdata <= '0;
    end else begin
      state <= next_state;
      own <= next_own;
      addr <= next_addr;
      we <= next_we;
      wdata <= next_wdata;
      sniff <= next_sniff;
      ref_cnt <= next_ref_cnt;
      ref_due <= next_ref_due;
      cpu_done <= next_cpu_done;
      dch_done <= next_dch_done;
      bmc_done <= next_bmc_done;
      cpu_rdata <= next_cpu_rdata;
      io_rdata <= next_io_rdata;
      err_single <= next_err_single;
      err_multi <= next_err_multi;
      err_addr <= next_err_addr;
      mem_req <= next_mem_req;
      mem_we <= next_mem_we;
      mem_refresh <= next_mem_refresh;
      mem_bank <= next_mem_bank;
      mem_row <= next_mem_row;
      mem_sel <= next_mem_sel;
      mem_wdata <= next_mem_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Cache arrays
  always_ff @(posedge clk) begin
    if (fill_en) begin
      ctag[fill_way][fill_idx] <= fill_page;
      for (int i = 0; i < tcmc_pkg::BLK_WORDS; i++) begin
        cdata[fill_way][fill_idx][i] <= merged[i/2][(i%2)*tcmc_pkg::WORD_W +: tcmc_pkg::WORD_W];
      end
    end
    if (word_en) begin
      cdata[word_way][word_idx][word_sel] <= word_val;
    end
  end

  // Clear wins over a fill in the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NIDX; i++) begin
        valid[i] <= '0;
        lru[i] <= tcmc_pkg::LRU_RESET;
      end
    end else begin
      if (lru_en) lru[lru_idx] <= lru_val;
      if (vcon_enter) begin
        for (int i = 0; i < NIDX; i++) valid[i] <= '0;
      end else begin
        if (fill_en) valid[fill_idx][fill_way] <= 1'b1;
        if (inv_en) valid[inv_idx] <= valid[inv_idx] & ~inv_ways;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  logic [CNT_W:0] since_tick;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) since_tick <= '0;
    else since_tick <= (ref_cnt == '0) ? '0 : since_tick + 1'b1;
  end

  sequence idle_grant_s;
    state == ST_IDLE && !gap && !ref_due;
  endsequence

  dch_first_a: assert property (
    idle_grant_s and dch_req |=> own == tcmc_pkg::OWN_DCH && mem_req)
    else $error("Data channel not granted first");
  bmc_second_a: assert property (
    idle_grant_s and !dch_req && bmc_req |=> own == tcmc_pkg::OWN_BMC)
    else $error("Burst channel not granted over processor");
  ref_period_a: assert property (
    ref_cnt == '0 && $past(ref_cnt) != '0 |-> since_tick == REFRESH_CYC - 1)
    else $error("Refresh tick spacing wrong");
  sniff_issue_a: assert property (
    state == ST_IDLE && !gap && ref_due |=> mem_req && mem_refresh && mem_sel == 2'h3)
    else $error("Refresh sniff not issued");
  hit_read_a: assert property (
    idle_grant_s and !dch_req && !bmc_req && cpu_req && !cpu_we && |cpu_hit
    |=> cpu_done && !mem_req)
    else $error("Read hit not served from cache");
  store_mem_a: assert property (
    idle_grant_s and !dch_req && !bmc_req && cpu_req && cpu_we
    |=> mem_req && we ##1 state == ST_RD)
    else $error("Store not sent to memory");
  fill_cpu_a: assert property (
    fill_en |-> own == tcmc_pkg::OWN_CPU && !we && fill_way == !lru[fill_idx])
    else $error("Fill from wrong owner or set");
  vcon_clear_a: assert property (
    vcon_enter |=> valid[$past(fill_idx)] == '0 && valid[0] == '0)
    else $error("Cache not invalidated on console entry");
  io_inval_a: assert property (
    inv_en && |inv_ways |=> (valid[$past(inv_idx)] & $past(inv_ways)) == '0)
    else $error("Channel write hit left block valid");
  err_rec_a: assert property (
    state == ST_RD && mem_ack && ecc_enable && |(ecc_bus.single & mem_sel) |=> err_single)
    else $error("Single error not recorded");
  two_bank_a: assert property (
    $rose(mem_req) && mod_size == tcmc_pkg::SIZE_1M |-> mem_bank[1] == 1'b0)
    else $error("Two-bank module addressed a third bank");
endmodule

/* bench/tcmc_mem_model.sv */
// Purpose: Memory array answering controller operations
// Assumes: Unwritten pairs read as zero codewords
// Notes: flip is xored into the low data bits of each read
`timescale 1ns/1ps
module tcmc_mem_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [1:0] mem_bank,
  input wire logic [15:0] mem_row,
  input wire logic [1:0] mem_sel,
  input wire logic [77:0] mem_wdata,
  input wire logic [3:0] lat,
  input wire logic [1:0] flip,
  output logic mem_ack,
  output logic [77:0] mem_rdata
);
  logic [77:0] store [int];
  logic [77:0] w;
  int cnt;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      store.delete();
      cnt <= 0;
      mem_ack <= 1'b0;
      mem_rdata <= '0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      cnt <= (mem_req && !mem_ack) ? cnt + 1 : 0;
      if (mem_req && !mem_ack && cnt >= lat) begin
        w = store.exists({mem_bank, mem_row}) ? store[{mem_bank, mem_row}] : '0;
        for (int l = 0; l < 2; l++) begin
          if (mem_sel[l] && mem_we) w[39*l+:39] = mem_wdata[39*l+:39];
        end
        store[{mem_bank, mem_row}] = w;
        mem_ack <= 1'b1;
        mem_rdata <= mem_we ? ~w : w ^ 78'(flip);
      end
    end
  end
endmodule

/* bench/tb_tcmc_top.sv */
// Purpose: Self-checking bench for the cache and memory control unit
// Assumes: Port 0 processor, 1 data channel, 2 burst channel
// Notes: Refresh interval shortened to 20 cycles
`timescale 1ns/1ps
module tb_tcmc_top;
  logic clk = 0, rst_b, vcon = 0, ecc_en = 1, err_clr = 0, err_s, err_m, mreq, mwe, mref, ack;
  logic [1:0] msz = 0, flip = 0, bank, sel;
  logic [2:0] req = 0, we = 0;
  wire [2:0] done;
  logic [19:0] addr [3] = '{default: 0};
  logic [19:0] cur = 0, ea;
  logic [15:0] wd [3] = '{default: 0};
  logic [15:0] cpu_rd, io_rd, rd, row;
  logic [15:0] shadow [int];
  logic [77:0] mwd, mrd;
  logic [3:0] lat = 0;
  int failures = 0, tests_run = 0, nops = 0, nref = 0, ord, seed = 28;
  tcmc_top #(.REFRESH_CYC(20)) u_tcmc_top (.clk(clk), .rst_b(rst_b), .cpu_req(req[0]),
    .cpu_we(we[0]), .cpu_addr(addr[0]), .cpu_wdata(wd[0]), .cpu_done(done[0]),
    .cpu_rdata(cpu_rd), .dch_req(req[1]), .dch_we(we[1]), .dch_addr(addr[1]),
    .dch_wdata(wd[1]), .dch_done(done[1]), .bmc_req(req[2]), .bmc_we(we[2]),
    .bmc_addr(addr[2]), .bmc_wdata(wd[2]), .bmc_done(done[2]), .io_rdata(io_rd),
    .vcon_enter(vcon), .mod_size(msz), .ecc_enable(ecc_en), .err_clear(err_clr),
    .err_single(err_s), .err_multi(err_m), .err_addr(ea), .mem_req(mreq), .mem_we(mwe),
    .mem_refresh(mref), .mem_bank(bank), .mem_row(row), .mem_sel(sel), .mem_wdata(mwd),
    .mem_ack(ack), .mem_rdata(mrd));
  tcmc_mem_model u_tcmc_mem_model (.clk(clk), .rst_b(rst_b), .mem_req(mreq), .mem_we(mwe),
    .mem_bank(bank), .mem_row(row), .mem_sel(sel), .mem_wdata(mwd), .lat(lat),
    .flip(flip), .mem_ack(ack), .mem_rdata(mrd));
  always #5 clk = ~clk;
  ////////////////////////////////////////
  function automatic logic [17:0] loc(input logic [19:0] a);
    return (msz == 2'h1) ? {1'b0, a[2], a[18:3]} : {a[3:2], a[19:4]};
  endfunction
  function automatic logic [15:0] memv(input logic [19:0] a);
    return shadow.exists(a) ? shadow[a] : 16'h0000;
  endfunction
  // Count answered operations; a store keeps mem_req high across both halves
  always @(negedge clk) begin
    if (ack && mref && !mwe) nref++;
    if (ack && !mref) begin
      nops++;
      chk(32'({bank, row}), 32'(loc(cur))); // Bank rotation
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic op(input int p, input logic w, input logic [19:0] a, input logic [15:0] d);
    int t;
    t = 0;
    cur = a;
    nops = 0;
    we[p] = w;
    addr[p] = a;
    wd[p] = d;
    req[p] = 1'b1;
    do begin
      tick();
      t++;
    end while (done[p] !== 1'b1 && t < 400);
    if (t >= 400) failures++;
    rd = (p == 0) ? cpu_rd : io_rd;
    req[p] = 1'b0;
    tick();
  endtask
  task automatic crd(input logic [19:0] a, input int n, input logic [15:0] x);
    op(0, 1'b0, a, 16'h0000);
    chk(32'(rd), 32'(x)); // Data
    if (n >= 0) chk(nops, n); // Hit or fill
  endtask
  task automatic wr(input int p, input logic [19:0] a, input logic [15:0] d);
    op(p, 1'b1, a, d);
    shadow[a] = d;
    chk(nops, 2); // Store reaches memory
  endtask
  task automatic iord(input int p, input logic [19:0] a);
    op(p, 1'b0, a, 16'h0000);
    chk(32'(rd), 32'(memv(a))); // Direct read
    chk(nops, 1); // No cache use
  endtask
  task automatic corner();
    logic [19:0] a [9];
    for (int i = 0; i < 9; i++) a[i] = {10'(i + 8), 8'h05, 2'h0};
    for (int i = 0; i < 9; i++) wr(1, a[i], 16'($random(seed)));
    crd(a[0], 1, memv(a[0])); // Cold
    crd(a[0], 0, memv(a[0])); // Hit
    crd(a[1], 1, memv(a[1])); // Other set
    crd(a[0], 0, memv(a[0])); // Both held
    crd(a[1], 0, memv(a[1])); // Flag marks a0 set
    crd(a[2], 1, memv(a[2])); // Evicts a0
    crd(a[1], 0, memv(a[1])); // Kept
    crd(a[0], 1, memv(a[0])); // Gone
    wr(0, a[1], 16'h5a5a);
    crd(a[1], 0, 16'h5a5a); // Copy updated
    wr(0, a[3], 16'h0f0f);
    crd(a[3], 1, 16'h0f0f); // No allocate
    for (int p = 1; p < 3; p++) begin
      crd(a[3], 0, memv(a[3])); // Held
      wr(p, a[3], 16'(16'h1230 + p));
      crd(a[3], 1, memv(a[3])); // Invalidated
    end
    iord(2, a[4]);
    crd(a[4], 1, memv(a[4])); // Not filled
    crd(a[4], 0, memv(a[4])); // Held
    vcon = 1'b1;
    tick();
    vcon = 1'b0;
    crd(a[4], 1, memv(a[4])); // Console entry
    flip = 2'h1;
    crd(a[5], 1, memv(a[5])); // Corrected
    chk(err_s, 1'b1); // Single noted
    chk(32'(ea), 32'(a[5])); // Error address
    flip = 2'h3;
    op(0, 1'b0, a[6], 16'h0000);
    chk(err_m, 1'b1); // Double noted
    flip = 2'h0;
    // Let a sniff answer read under the old flip land before clearing
    tick();
    err_clr = 1'b1;
    tick();
    err_clr = 1'b0;
    chk({err_s, err_m}, 2'h0); // Cleared
    ecc_en = 1'b0;
    flip = 2'h1;
    crd(a[7], 1, memv(a[7]) ^ 16'h0001); // Raw when off
    chk(err_s, 1'b0); // Nothing noted
    flip = 2'h0;
    ecc_en = 1'b1;
    nref = 0;
    repeat (200) tick();
    chk(nref >= 9 && nref <= 10, 1'b1); // Refresh period
    we = 3'h0;
    addr = '{default: a[8]};
    cur = a[8];
    ord = 0;
    req = 3'h7;
    repeat (80) begin
      tick();
      for (int p = 0; p < 3; p++) begin
        if (done[p] === 1'b1) begin
          ord = ord * 4 + p;
          req[p] = 1'b0;
        end
      end
    end
    chk(ord, 24); // Data, burst, processor
  endtask
  task automatic close_out();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    for (int s = 0; s < 3; s++) begin
      msz = 2'(s);
      rst_b = 1'b0;
      shadow.delete();
      repeat (3) tick();
      rst_b = 1'b1;
      tick();
      corner();
      repeat (250) begin
        cur = 20'($random(seed)) & 20'h00c0f;
        lat = 4'($random(seed)) & 4'h3;
        ord = {$random(seed)} % 3;
        if ($random(seed) & 1) wr(ord, cur, 16'($random(seed)));
        else if (ord == 0) crd(cur, -1, memv(cur)); // Coherent
        else iord(ord, cur);
      end
    end
    close_out();
  end
  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    close_out();
  end
endmodule
